//--- ble_engine.sv
// Boolean logic command engine: fetches program lines and runs load/AND/store bit commands
//
// Contract
// R1: An instruction is one command plus zero to three arguments, decoded per command.
// R2: Instructions execute one after another in program line order, one per line.
// R3: Keep a one-bit Boolean accumulator and a separate unsigned 16-bit accumulator.
// R4: Constant load puts its zero-or-one argument into the Boolean accumulator.
// R5: General load copies control register bit (arg 2) at address arg 1.
// R6: Scratch load copies the chosen bit of the addressed scratch register.
// R7: Persistent load copies the chosen bit of the addressed persistent register.
// R8: Inverted general load writes the complement of the addressed control bit.
// R9: Inverted scratch load writes the complement of the chosen scratch bit.
// R10: Inverted persistent load writes the complement of the chosen persistent bit.
// R11: General AND combines accumulator with the addressed control register bit.
// R12: Scratch AND combines accumulator with the chosen scratch register bit.
// R13: Persistent AND combines accumulator with the chosen persistent register bit.
// R14: Inverted general AND uses the complement of the control register bit.
// R15: Inverted scratch AND uses the complement of the scratch register bit.
// R16: Scratch store writes the Boolean accumulator into the chosen scratch bit.
// R17: Each command has a fixed opcode and argument field layout.
// R18: An end instruction ends the program; the next scan restarts at line zero.
module ble_engine
  import ble_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Run control from same-domain logic
  input  wire logic               run_en,
  // Program download
  input  wire logic               prog_wr_en,
  input  wire logic [PC_W-1:0]    prog_wr_addr,
  input  wire logic [INSTR_W-1:0] prog_wr_data,
  // Persistent register load
  input  wire logic               persist_wr_en,
  input  wire logic [SPACE_AW-1:0] persist_wr_addr,
  input  wire logic [WORD_W-1:0]  persist_wr_data,
  // Control register read port
  output logic      [WORD_W-1:0]  ctrl_rd_addr_q,
  input  wire logic [WORD_W-1:0]  ctrl_rd_data,
  // Status
  output logic                    bool_acc_q,
  output logic      [WORD_W-1:0]  word_acc_q,
  output logic      [WORD_W-1:0]  program_identifier_q,
  output logic      [PC_W-1:0]    pc_q,
  output logic                    scan_done_q,
  output logic                    bad_opcode_q
);
  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic [BITNO_W-1:0] n);
    pick_bit = w[n];
  endfunction

  ble_state_e         state_q;
  logic [INSTR_W-1:0] mem_rdata;
  logic [INSTR_W-1:0] instr_q;
  logic [WORD_W-1:0]  scratch_q [SPACE_CNT];
  logic [WORD_W-1:0]  persist_q [SPACE_CNT];
  ble_op_e            op;
  logic [WORD_W-1:0]  arg1;
  logic [BITNO_W-1:0] bitno;
  logic [SPACE_AW-1:0] sidx;
  logic               gen_bit;
  logic               scr_bit;
  logic               per_bit;
  logic               exec;
  logic               bool_d;
  logic               legal;

  // Field split of the latched instruction word
  assign op      = ble_op_e'(instr_q[OP_MSB:OP_LSB]);      // [R17]
  assign arg1    = instr_q[A1_MSB:A1_LSB];                 // [R1]
  assign bitno   = instr_q[A2_LSB+BITNO_W-1:A2_LSB];       // [R1]
  assign sidx    = arg1[SPACE_AW-1:0];
  assign gen_bit = pick_bit(ctrl_rd_data, bitno);
  assign scr_bit = pick_bit(scratch_q[sidx], bitno);
  assign per_bit = pick_bit(persist_q[sidx], bitno);
  assign exec    = (state_q == ST_EXEC);

  ble_prog_mem u_mem (
    .clk       (clk),
    .wr_en     (prog_wr_en),
    .wr_addr   (prog_wr_addr),
    .wr_data   (prog_wr_data),
    .rd_addr   (pc_q),
    .rd_data_q (mem_rdata)
  );

  // Fetch, decode, execute: three cycles per program line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:   state_q <= run_en ? ST_FETCH : ST_IDLE;
        ST_FETCH:  state_q <= ST_DECODE;
        ST_DECODE: state_q <= ST_EXEC;
        ST_EXEC:   state_q <= run_en ? ST_FETCH : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q        <= '0;
      ctrl_rd_addr_q <= WORD_RST;
    end else if (state_q == ST_DECODE) begin
      instr_q        <= mem_rdata;
      ctrl_rd_addr_q <= mem_rdata[A1_MSB:A1_LSB];  // [R5]
    end
  end

  // Program counter: next line, or back to line zero on the end marker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PC_RST;
    end else if (exec) begin
      if (op == OP_END) begin
        pc_q <= PC_RST;  // [R18]
      end else begin
        pc_q <= pc_q + PC_STEP;  // [R2]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_done_q <= 1'b0;
    end else begin
      scan_done_q <= exec && (op == OP_END);  // [R18]
    end
  end

  // Boolean accumulator next value
  always_comb begin
    bool_d = bool_acc_q;
    legal  = 1'b1;
    case (op)
      OP_LOAD_CONST_BOOL:       bool_d = arg1[0];                  // [R4]
      OP_LOAD_GEN_BOOL:         bool_d = gen_bit;                  // [R5]
      OP_LOAD_SCRATCH_BOOL:     bool_d = scr_bit;                  // [R6]
      OP_LOAD_PERSIST_BOOL:     bool_d = per_bit;                  // [R7]
      OP_LOAD_INV_GEN_BOOL:     bool_d = ~gen_bit;                 // [R8]
      OP_LOAD_INV_SCRATCH_BOOL: bool_d = ~scr_bit;                 // [R9]
      OP_LOAD_INV_PERSIST_BOOL: bool_d = ~per_bit;                 // [R10]
      OP_CONJ_GEN_BOOL:         bool_d = bool_acc_q & gen_bit;     // [R11]
      OP_CONJ_SCRATCH_BOOL:     bool_d = bool_acc_q & scr_bit;     // [R12]
      OP_CONJ_PERSIST_BOOL:     bool_d = bool_acc_q & per_bit;     // [R13]
      OP_CONJ_INV_GEN_BOOL:     bool_d = bool_acc_q & ~gen_bit;    // [R14]
      OP_CONJ_INV_SCRATCH_BOOL: bool_d = bool_acc_q & ~scr_bit;    // [R15]
      OP_CONJ_INV_PERSIST_BOOL: bool_d = bool_acc_q & ~per_bit;
      OP_END, OP_PROGRAM_IDENTIFIER, OP_STORE_SCRATCH_BOOL: bool_d = bool_acc_q;
      default:                  legal  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bool_acc_q <= BOOL_RST;  // [R3]
    end else if (exec) begin
      bool_acc_q <= bool_d;
    end
  end

  // Word accumulator: no command of this group changes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_acc_q <= WORD_RST;  // [R3]
    end else begin
      word_acc_q <= word_acc_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_identifier_q <= WORD_RST;
    end else if (exec && op == OP_PROGRAM_IDENTIFIER) begin
      program_identifier_q <= arg1;
    end
  end

  // Unknown opcodes act as no-ops and raise a sticky flag until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_opcode_q <= 1'b0;
    end else if (exec && !legal) begin
      bad_opcode_q <= 1'b1;  // [R17]
    end
  end

  for (genvar g = 0; g < SPACE_CNT; g++) begin : g_space
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        scratch_q[g] <= WORD_RST;
      end else if (exec && op == OP_STORE_SCRATCH_BOOL && sidx == SPACE_AW'(g)) begin
        scratch_q[g][bitno] <= bool_acc_q;  // [R16]
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        persist_q[g] <= WORD_RST;
      end else if (persist_wr_en && persist_wr_addr == SPACE_AW'(g)) begin
        persist_q[g] <= persist_wr_data;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_line;
    state_q == ST_FETCH ##1 state_q == ST_DECODE ##1 state_q == ST_EXEC;
  endsequence

  property p_line_steps;
    state_q == ST_FETCH |-> s_line;
  endproperty
  a_line_steps: assert property (p_line_steps) else $error("line did not take fetch-decode-exec"); // [R2]

  property p_pc_next;
    exec && op != OP_END |=> pc_q == $past(pc_q) + PC_STEP;
  endproperty
  a_pc_next: assert property (p_pc_next) else $error("pc did not advance by one"); // [R2]

  property p_end_restart;
    exec && op == OP_END |=> pc_q == PC_RST && scan_done_q;
  endproperty
  a_end_restart: assert property (p_end_restart) else $error("end marker did not restart scan"); // [R18]

  property p_load_const;
    exec && op == OP_LOAD_CONST_BOOL |=> bool_acc_q == $past(arg1[0]);
  endproperty
  a_load_const: assert property (p_load_const) else $error("constant load wrong"); // [R4]

  property p_load_gen;
    exec && op == OP_LOAD_GEN_BOOL |=> bool_acc_q == $past(ctrl_rd_data[bitno]);
  endproperty
  a_load_gen: assert property (p_load_gen) else $error("general load wrong"); // [R5]

  property p_load_gen_addr;
    state_q == ST_DECODE |=> ctrl_rd_addr_q == $past(mem_rdata[A1_MSB:A1_LSB]);
  endproperty
  a_load_gen_addr: assert property (p_load_gen_addr) else $error("control address not argument 1"); // [R5]

  property p_load_scratch;
    exec && op == OP_LOAD_SCRATCH_BOOL |=> bool_acc_q == $past(scratch_q[sidx][bitno]);
  endproperty
  a_load_scratch: assert property (p_load_scratch) else $error("scratch load wrong"); // [R6]

  property p_load_persist;
    exec && op == OP_LOAD_PERSIST_BOOL |=> bool_acc_q == $past(persist_q[sidx][bitno]);
  endproperty
  a_load_persist: assert property (p_load_persist) else $error("persistent load wrong"); // [R7]

  property p_load_inv_gen;
    exec && op == OP_LOAD_INV_GEN_BOOL |=> bool_acc_q != $past(ctrl_rd_data[bitno]);
  endproperty
  a_load_inv_gen: assert property (p_load_inv_gen) else $error("inverted general load wrong"); // [R8]

  property p_conj_gen;
    exec && op == OP_CONJ_GEN_BOOL |=> bool_acc_q == ($past(bool_acc_q) & $past(ctrl_rd_data[bitno]));
  endproperty
  a_conj_gen: assert property (p_conj_gen) else $error("general AND wrong"); // [R11]

  property p_conj_inv_scratch;
    exec && op == OP_CONJ_INV_SCRATCH_BOOL |=>
      bool_acc_q == ($past(bool_acc_q) & ~$past(scratch_q[sidx][bitno]));
  endproperty
  a_conj_inv_scratch: assert property (p_conj_inv_scratch) else $error("inverted scratch AND wrong"); // [R15]

  property p_store_scratch;
    exec && op == OP_STORE_SCRATCH_BOOL |=> scratch_q[$past(sidx)][$past(bitno)] == $past(bool_acc_q);
  endproperty
  a_store_scratch: assert property (p_store_scratch) else $error("scratch store wrong"); // [R16]
endmodule

//--- ble_pkg.sv
// Constants, opcodes and states shared by the logic command engine
package ble_pkg;
  localparam int unsigned PC_W      = 8;
  localparam int unsigned PROG_DEPTH = 256;
  localparam int unsigned INSTR_W   = 32;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BITNO_W   = 4;
  localparam int unsigned SPACE_AW  = 4;
  localparam int unsigned SPACE_CNT = 16;
  // Instruction word layout: opcode, argument 1, argument 2, argument 3
  localparam int unsigned OP_MSB    = 31;
  localparam int unsigned OP_LSB    = 26;
  localparam int unsigned A1_MSB    = 25;
  localparam int unsigned A1_LSB    = 10;
  localparam int unsigned A2_MSB    = 9;
  localparam int unsigned A2_LSB    = 4;
  localparam int unsigned A3_MSB    = 3;
  localparam int unsigned A3_LSB    = 0;
  // Reset values and program counter step
  localparam logic [PC_W-1:0]   PC_RST   = 8'h00;
  localparam logic [PC_W-1:0]   PC_STEP  = 8'h01;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic              BOOL_RST = 1'b0;

  typedef enum logic [5:0] {
    OP_END                   = 6'h00,
    OP_PROGRAM_IDENTIFIER    = 6'h01,
    OP_LOAD_CONST_BOOL       = 6'h02,
    OP_LOAD_GEN_BOOL         = 6'h03,
    OP_LOAD_SCRATCH_BOOL     = 6'h04,
    OP_LOAD_PERSIST_BOOL     = 6'h05,
    OP_LOAD_INV_GEN_BOOL     = 6'h06,
    OP_LOAD_INV_SCRATCH_BOOL = 6'h07,
    OP_LOAD_INV_PERSIST_BOOL = 6'h08,
    OP_CONJ_GEN_BOOL         = 6'h09,
    OP_CONJ_SCRATCH_BOOL     = 6'h0a,
    OP_CONJ_PERSIST_BOOL     = 6'h0b,
    OP_CONJ_INV_GEN_BOOL     = 6'h0c,
    OP_CONJ_INV_SCRATCH_BOOL = 6'h0d,
    OP_CONJ_INV_PERSIST_BOOL = 6'h0e,
    OP_STORE_SCRATCH_BOOL    = 6'h0f
  } ble_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_EXEC
  } ble_state_e;
endpackage

//--- ble_prog_mem.sv
// Program store: one write port for download, one registered read port
module ble_prog_mem
  import ble_pkg::*;
(
  // Clock
  input  wire logic               clk,
  // Download write port
  input  wire logic               wr_en,
  input  wire logic [PC_W-1:0]    wr_addr,
  input  wire logic [INSTR_W-1:0] wr_data,
  // Fetch read port
  input  wire logic [PC_W-1:0]    rd_addr,
  output logic      [INSTR_W-1:0] rd_data_q
);
  logic [INSTR_W-1:0] mem [PROG_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q <= mem[rd_addr];
  end
endmodule

//--- ble_tool_model.sv
// Programming tool model: downloads program lines and persistent words, serves control registers
module ble_tool_model
  import ble_pkg::*;
#(
  parameter logic [WORD_W-1:0] CTRL_KEY = 16'h5a3c
)
(
  // Clock
  input  wire logic                clk,
  // Program download
  output logic                     prog_wr_en,
  output logic      [PC_W-1:0]     prog_wr_addr,
  output logic      [INSTR_W-1:0]  prog_wr_data,
  // Persistent register load
  output logic                     persist_wr_en,
  output logic      [SPACE_AW-1:0] persist_wr_addr,
  output logic      [WORD_W-1:0]   persist_wr_data,
  // Control register read port
  input  wire logic [WORD_W-1:0]   ctrl_rd_addr_q,
  output logic      [WORD_W-1:0]   ctrl_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each control register reads as its address scrambled by a key
  assign ctrl_rd_data = ctrl_rd_addr_q ^ CTRL_KEY;

  initial begin
    prog_wr_en      = 1'b0;
    prog_wr_addr    = 8'h00;
    prog_wr_data    = 32'h0000_0000;
    persist_wr_en   = 1'b0;
    persist_wr_addr = 4'h0;
    persist_wr_data = 16'h0000;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic write_line(input logic [PC_W-1:0] a, input logic [INSTR_W-1:0] d);
    @(posedge clk);
    #1;
    prog_wr_en   = 1'b1;
    prog_wr_addr = a;
    prog_wr_data = d;
    @(posedge clk);
    #1;
    prog_wr_en   = 1'b0;
    prog_wr_addr = ~a;
    prog_wr_data = ~d;
  endtask

  task automatic write_persist(input logic [SPACE_AW-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk);
    #1;
    persist_wr_en   = 1'b1;
    persist_wr_addr = a;
    persist_wr_data = d;
    @(posedge clk);
    #1;
    persist_wr_en   = 1'b0;
    persist_wr_addr = ~a;
    persist_wr_data = ~d;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the Boolean logic command engine
module tb_top
  import ble_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_W-1:0] KEY = 16'h5a3c;

  logic clk, rst_n, run_en, pw_en, qw_en, acc_q, sdone, bad_q;
  logic [PC_W-1:0] pw_addr, pc;
  logic [INSTR_W-1:0] pw_data;
  logic [SPACE_AW-1:0] qw_addr;
  logic [WORD_W-1:0] qw_data, c_addr, c_data, wacc, pid;
  int miscompares, n_tests, cycles;
  logic [WORD_W-1:0] scr[SPACE_CNT], per[SPACE_CNT], r_id;
  logic r_acc, r_bad;
  logic [INSTR_W-1:0] prog[$];

  ble_engine dut (.clk(clk), .rst_n(rst_n), .run_en(run_en), .prog_wr_en(pw_en), .prog_wr_addr(pw_addr),
    .prog_wr_data(pw_data), .persist_wr_en(qw_en), .persist_wr_addr(qw_addr), .persist_wr_data(qw_data),
    .ctrl_rd_addr_q(c_addr), .ctrl_rd_data(c_data), .bool_acc_q(acc_q), .word_acc_q(wacc),
    .program_identifier_q(pid), .pc_q(pc), .scan_done_q(sdone), .bad_opcode_q(bad_q));
  ble_tool_model #(.CTRL_KEY(KEY)) tool (.clk(clk), .prog_wr_en(pw_en), .prog_wr_addr(pw_addr),
    .prog_wr_data(pw_data), .persist_wr_en(qw_en), .persist_wr_addr(qw_addr), .persist_wr_data(qw_data),
    .ctrl_rd_addr_q(c_addr), .ctrl_rd_data(c_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test;
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [INSTR_W-1:0] ins(logic [5:0] op, logic [15:0] a1, logic [3:0] b);
    return {op, a1, 2'b00, b, 4'h0};
  endfunction

  // Reference execution of one line
  task automatic ref_step(input logic [INSTR_W-1:0] w);
    logic [5:0] op;
    logic [15:0] a1, g;
    logic [3:0] b, r;
    op = w[OP_MSB:OP_LSB];
    a1 = w[A1_MSB:A1_LSB];
    b = w[7:4];
    r = a1[3:0];
    g = a1 ^ KEY;
    case (op)
      OP_PROGRAM_IDENTIFIER: r_id = a1;
      OP_LOAD_CONST_BOOL: r_acc = a1[0];
      OP_LOAD_GEN_BOOL: r_acc = g[b];
      OP_LOAD_SCRATCH_BOOL: r_acc = scr[r][b];
      OP_LOAD_PERSIST_BOOL: r_acc = per[r][b];
      OP_LOAD_INV_GEN_BOOL: r_acc = ~g[b];
      OP_LOAD_INV_SCRATCH_BOOL: r_acc = ~scr[r][b];
      OP_LOAD_INV_PERSIST_BOOL: r_acc = ~per[r][b];
      OP_CONJ_GEN_BOOL: r_acc = r_acc & g[b];
      OP_CONJ_SCRATCH_BOOL: r_acc = r_acc & scr[r][b];
      OP_CONJ_PERSIST_BOOL: r_acc = r_acc & per[r][b];
      OP_CONJ_INV_GEN_BOOL: r_acc = r_acc & ~g[b];
      OP_CONJ_INV_SCRATCH_BOOL: r_acc = r_acc & ~scr[r][b];
      OP_CONJ_INV_PERSIST_BOOL: r_acc = r_acc & ~per[r][b];
      OP_STORE_SCRATCH_BOOL: scr[r][b] = r_acc;
      OP_END: ;
      default: r_bad = 1'b1;
    endcase
  endtask

  task automatic do_reset;
    step;
    rst_n = 1'b0;
    run_en = 1'b0;
    repeat (2) step;
    rst_n = 1'b1;
    foreach (scr[k]) scr[k] = 16'h0000;
    foreach (per[k]) per[k] = 16'h0000;
    r_acc = BOOL_RST;
    r_bad = 1'b0;
    r_id = WORD_RST;
  endtask

  // Download prog, run one scan, optionally dropping run_en after line pa so the engine pauses after line pa+1
  task automatic run_prog(int pa);
    int i, n;
    for (i = 0; i < prog.size(); i++) tool.write_line(PC_W'(i), prog[i]);
    step;
    run_en = 1'b1;
    for (i = 0; i < prog.size() - 1; i++) begin
      n = 0;
      do begin
        step;
        n++;
      end while (pc !== PC_W'(i + 1) && n < 12);
      ref_step(prog[i]);
      check("pc", pc, PC_W'(i + 1));
      check("ctrl addr", c_addr, prog[i][A1_MSB:A1_LSB]);
      check("bool acc", acc_q, r_acc);
      check("bad opcode", bad_q, r_bad);
      if (i > 0 && i != pa + 2) check("line cycles", n, 3);
      if (i == pa) run_en = 1'b0;
      if (i == pa + 1) begin
        repeat (8) step;
        check("paused pc", pc, PC_W'(i + 1));
        run_en = 1'b1;
      end
    end
    n = 0;
    do begin
      step;
      n++;
    end while (sdone !== 1'b1 && n < 12);
    check("scan done", sdone, 1);
    check("end cycles", n, 3);
    check("restart pc", pc, 0);
    run_en = 1'b0;
    check("word acc", wacc, WORD_RST);
    check("identifier", pid, r_id);
  endtask

  task automatic s_control;
    do_reset;
    prog = '{ins(OP_PROGRAM_IDENTIFIER, 16'h4d21, 0), ins(OP_LOAD_CONST_BOOL, 1, 0),
      ins(OP_LOAD_GEN_BOOL, 0, 0), ins(OP_LOAD_INV_GEN_BOOL, 0, 0), ins(OP_CONJ_GEN_BOOL, 0, 2),
      ins(OP_CONJ_INV_GEN_BOOL, 0, 15), ins(OP_CONJ_GEN_BOOL, 16'hffff, 15),
      ins(OP_CONJ_INV_GEN_BOOL, 16'hffff, 0), ins(OP_LOAD_GEN_BOOL, 16'hffff, 15), ins(OP_END, 0, 0)};
    run_prog(3);
  endtask

  task automatic s_scratch;
    do_reset;
    prog = '{ins(OP_LOAD_CONST_BOOL, 1, 0), ins(OP_STORE_SCRATCH_BOOL, 15, 15), ins(OP_LOAD_CONST_BOOL, 0, 0),
      ins(OP_STORE_SCRATCH_BOOL, 0, 0), ins(OP_LOAD_SCRATCH_BOOL, 15, 15), ins(OP_CONJ_INV_SCRATCH_BOOL, 0, 0),
      ins(OP_CONJ_SCRATCH_BOOL, 15, 15), ins(OP_LOAD_INV_SCRATCH_BOOL, 15, 14),
      ins(OP_CONJ_SCRATCH_BOOL, 15, 14), ins(OP_LOAD_INV_SCRATCH_BOOL, 15, 15), ins(OP_END, 0, 0)};
    run_prog(-9);
  endtask

  task automatic s_persist;
    do_reset;
    per[0] = 16'h8001;
    per[15] = 16'h7ffe;
    tool.write_persist(4'h0, per[0]);
    tool.write_persist(4'hf, per[15]);
    prog = '{ins(OP_LOAD_PERSIST_BOOL, 0, 15), ins(OP_CONJ_PERSIST_BOOL, 0, 0),
      ins(OP_CONJ_INV_PERSIST_BOOL, 15, 0), ins(OP_CONJ_PERSIST_BOOL, 15, 15),
      ins(OP_LOAD_INV_PERSIST_BOOL, 15, 15), ins(OP_CONJ_INV_PERSIST_BOOL, 0, 15), ins(OP_END, 0, 0)};
    run_prog(-9);
  endtask

  task automatic s_bad;
    do_reset;
    prog = '{ins(OP_LOAD_CONST_BOOL, 1, 0), ins(6'h3f, 16'h0001, 3), ins(6'h10, 0, 0), ins(OP_END, 0, 0)};
    run_prog(-9);
  endtask

  initial begin
    rst_n = 1'b0;
    run_en = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    s_control;
    s_scratch;
    s_persist;
    s_bad;
    end_of_test;
  end
endmodule
